// [sim/host_link_model.sv]
// host-side link model: one valid frame pulse per request
`timescale 1ns/1ns
module host_link_model (
    // clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // request from the bench
    input wire logic send,
    input wire logic [3:0] gap,
    // frame strobe to the device
    output logic frame_valid
);
    logic [4:0] wait_q;
    // long gap models a slow host; frame strobe lasts one cycle only
    always_ff @(posedge clock) begin
        frame_valid <= rst_b && wait_q == 5'h1;
        if (!rst_b) wait_q <= 5'h0;
        else if (send) wait_q <= {1'b0, gap} + 5'h1;
        else if (wait_q != 5'h0) wait_q <= wait_q - 5'h1;
    end
endmodule // host_link_model

// [sim/silence_checker_sva.sv]
// port assertions for the link-silence supervisor
`timescale 1ns/1ns
module silence_checker
    import silence_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // register access
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_hit,
    // link and results
    input wire logic frame_valid,
    input wire logic count_clear_inhibit,
    input wire logic link_silence_fault_clear,
    input wire logic link_silence_fault,
    input wire logic shutdown_request,
    input wire logic controller_shutdown_cause,
    input wire logic [23:0] silence_tick_count
);
    // ********
    // config shadow
    // ********
    logic [7:0] cfg_q;
    logic [7:0] cfg_d;
    // limits follow what the host wrote, not the design's own copy
    always_comb cfg_d = (reg_wr && reg_addr == 8'h28) ? reg_wdata : cfg_q;
    always_ff @(posedge clock) cfg_q <= rst_b ? cfg_d : 8'h00;
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    property p_fault;
        !reg_wr && !frame_valid && period_ticks[cfg_q[3:0]] != 0 &&
        silence_tick_count >= period_ticks[cfg_q[3:0]] |=> link_silence_fault;
    endproperty
    a_fault: assert property (p_fault) else $error("fault missed");
    property p_pd;
        !reg_wr && !frame_valid && period_ticks[cfg_q[7:4]] != 0 &&
        silence_tick_count >= period_ticks[cfg_q[7:4]] |=> shutdown_request;
    endproperty
    a_pd: assert property (p_pd) else $error("shutdown missed");
    property p_cause;
        $rose(shutdown_request) |-> controller_shutdown_cause;
    endproperty
    a_cause: assert property (p_cause) else $error("cause not set");
    property p_sd_hold;
        shutdown_request |=> shutdown_request;
    endproperty
    a_sd_hold: assert property (p_sd_hold) else $error("shutdown dropped");
    property p_f_hold;
        link_silence_fault && !link_silence_fault_clear |=> link_silence_fault;
    endproperty
    a_f_hold: assert property (p_f_hold) else $error("fault dropped");
    property p_clear;
        frame_valid && !count_clear_inhibit && !reg_wr |=> silence_tick_count == 24'h00_0000;
    endproperty
    a_clear: assert property (p_clear) else $error("frame did not clear");
    property p_load;
        reg_wr && reg_addr == 8'h2B |=> silence_tick_count[7:0] == $past(reg_wdata);
    endproperty
    a_load: assert property (p_load) else $error("count not loaded");
    property p_step;
        !reg_wr && !frame_valid |=> silence_tick_count == $past(silence_tick_count) ||
        silence_tick_count == $past(silence_tick_count) + 24'h00_0001;
    endproperty
    a_step: assert property (p_step) else $error("count jumped");
    property p_rd;
        reg_rd && !reg_wr && reg_addr == 8'h28 |=> reg_rdata == $past(cfg_q);
    endproperty
    a_rd: assert property (p_rd) else $error("config readback");
endmodule // silence_checker
bind comm_silence_timeout silence_checker chk_i (.*);

// [sim/tb_top.sv]
// self-checking bench for the link-silence supervisor
`timescale 1ns/1ns
module tb_top
    import silence_pkg::*;
;
    logic clock = 0, rst_b = 0, reg_wr = 0, reg_rd = 0, send = 0;
    logic count_clear_inhibit = 0, link_silence_fault_clear = 0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
    logic [3:0] gap = 4'h0;
    logic reg_hit, frame_valid, link_silence_fault, shutdown_request, controller_shutdown_cause, took;
    logic [23:0] silence_tick_count, v;
    logic [7:0] exp_q[$];
    int n_fail = 0, checks = 0;
    comm_silence_timeout #(.divide(4)) DUT (.*);
    host_link_model link (.*);
    initial forever #5 clock = ~clock;
    // ********
    // helpers
    // ********
    task automatic chk(input bit ok);
        checks++;
        if (!ok) begin
            n_fail++;
            $display("ERROR %0t mismatch", $time);
        end
    endtask
    // one register cycle; a read leaves its expected byte for the monitor
    task automatic acc(input bit w, input logic [7:0] a, d);
        @(posedge clock);
        reg_wr <= w;
        reg_rd <= !w;
        reg_addr <= a;
        reg_wdata <= d;
        if (!w) exp_q.push_back(d);
        // decode is combinational, so look at it mid-cycle while the address stands
        @(negedge clock);
        chk(reg_hit === (a >= silence_period_config_addr && a <= silence_tick_counter_last));
        @(posedge clock);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
    endtask
    // read data is registered, so compare on the cycle after the strobe
    always @(posedge clock) took <= reg_rd;
    always @(negedge clock) if (took) chk(reg_rdata === exp_q.pop_front());
    task automatic await(ref logic s, input int n);
        repeat (n) if (s !== 1'b1) @(negedge clock);
        chk(s === 1'b1);
    endtask
    // low byte cleared first so a tick cannot carry between byte writes
    task automatic preset(input logic [23:0] p);
        acc(1, 8'h2B, 8'h00);
        acc(1, 8'h29, p[23:16]);
        acc(1, 8'h2A, p[15:8]);
        acc(1, 8'h2B, p[7:0]);
    endtask
    task automatic pulse_clear;
        @(posedge clock) link_silence_fault_clear <= 1'b1;
        @(posedge clock) link_silence_fault_clear <= 1'b0;
    endtask
    task automatic do_reset;
        rst_b <= 1'b0;
        repeat (4) @(posedge clock);
        rst_b <= 1'b1;
    endtask
    task automatic tally_and_finish;
        $display("checks %0d failures %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // whole run is a few hundred cycles
    initial begin
        #300_000;
        n_fail++;
        tally_and_finish;
    end
    initial begin
        void'($urandom(32));
        do_reset;
        acc(0, 8'h28, 8'h00);
        acc(0, 8'h29, 8'h00);
        acc(1, 8'h30, 8'($urandom));
        acc(0, 8'h30, 8'h00);
        $display("test reset done");
        // fault codes 0 to 13, counter preset just short of each period (code 0 near full scale)
        count_clear_inhibit <= 1'b1;
        for (int c = 0; c < 14; c++) begin
            v = (c == 0) ? 24'hFF_FF00 : period_ticks[c] - 24'h00_0003;
            acc(1, 8'h28, 8'(c));
            preset(v);
            acc(0, 8'h29, v[23:16]);
            pulse_clear;
            // the flag changes on the clear edge, so wait until it has settled
            @(negedge clock);
            chk(link_silence_fault === 1'b0);
            if (c == 0) repeat (30) @(negedge clock);
            else await(link_silence_fault, 40);
            chk(c == 0 ? link_silence_fault === 1'b0 : silence_tick_count >= v);
            chk(shutdown_request === 1'b0);
        end
        $display("test fault codes done");
        for (int i = 0; i < 2; i++) begin
            count_clear_inhibit <= (i == 0);
            gap <= 4'($urandom);
            @(posedge clock) send <= 1'b1;
            @(posedge clock) send <= 1'b0;
            await(frame_valid, 20);
            @(negedge clock);
            chk((silence_tick_count == 24'h00_0000) === (i == 1));
        end
        $display("test frames done");
        count_clear_inhibit <= 1'b1;
        acc(1, 8'h28, 8'h21);
        preset(period_ticks[2] - 24'h00_0003);
        await(shutdown_request, 40);
        chk(controller_shutdown_cause === 1'b1 && link_silence_fault === 1'b1);
        do_reset;
        @(negedge clock);
        chk(shutdown_request === 1'b0 && silence_tick_count === 24'h00_0000);
        $display("test power-down done");
        tally_and_finish;
    end
endmodule // tb_top

// [verilog/comm_silence_timeout.sv]
// link-silence supervisor: silence counter, fault and power-down compare
`timescale 1ns/1ns

// Operation
// (RL1) a 24-bit counter counts up once per 4 kHz tick to measure time since the last valid frame.
// (RL2) the one counter serves both the power-down compare and the fault compare.
// (RL3) a register write to the counter loads the written value as the present count.
// (RL4) a read of the counter returns its live count, useful only while clearing is inhibited.
// (RL5) the upper config nibble selects the power-down period, 0 off, 1..13 from 0.1 s to 1 hour.
// (RL6) when the enabled power-down period is reached with no valid frame, shutdown is requested.
// (RL7) the lower config nibble selects the fault period with the same codes and durations.
// (RL8) when the enabled fault period elapses with no valid frame, the link-silence fault is set.
// (RL9) the host must not write codes 14 or 15 into either field.
// (RL10) the host should make the fault period shorter than the power-down period.
// (RL11) each valid frame clears the counter unless the clear-inhibit control is set.
// (RL12) a shutdown from power-down expiry records the controller shutdown cause bit.
module comm_silence_timeout
    import silence_pkg::*;
#(
    parameter int divide = tick_div
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // register access, byte wide
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic reg_hit,
    // link and control
    input wire logic frame_valid,
    input wire logic count_clear_inhibit,
    input wire logic link_silence_fault_clear,
    // results
    output logic link_silence_fault,
    output logic shutdown_request,
    output logic controller_shutdown_cause,
    output logic [23:0] silence_tick_count
);
    initial begin
        if (divide < 2) begin
            $error("comm_silence_timeout: divide must be at least 2");
        end
    end

    // ****************************************
    // time base
    // ****************************************
    logic tick;

    tick_divider #(.divide(divide)) u_tick (
        .clock(clock),
        .rst_b(rst_b),
        .tick(tick)
    );

    // ****************************************
    // state
    // ****************************************
    logic [7:0] config_q;
    logic [7:0] config_d;
    logic [23:0] count_q;
    logic [23:0] count_d;
    logic fault_q;
    logic fault_d;
    logic shut_q;
    logic shut_d;
    logic cause_q;
    logic cause_d;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;

    logic [3:0] silence_powerdown_period;
    logic [3:0] silence_fault_period;
    logic [23:0] pd_limit;
    logic [23:0] fault_limit;
    logic pd_hit;
    logic fault_hit;
    logic [1:0] byte_sel;

    assign silence_powerdown_period = config_q[pd_field_lsb +: field_width];
    assign silence_fault_period = config_q[fault_field_lsb +: field_width];
    // reserved codes decode as disabled; the table holds zero there
    assign pd_limit = period_ticks[silence_powerdown_period]; // [RL5]
    assign fault_limit = period_ticks[silence_fault_period]; // [RL7]
    // both compares read the same counter [RL2]
    assign pd_hit = (pd_limit != count_reset) && (count_q >= pd_limit); // [RL6]
    assign fault_hit = (fault_limit != count_reset) && (count_q >= fault_limit); // [RL8]
    assign byte_sel = 2'(reg_addr - silence_tick_counter_addr);

    // next state of counter, config, flags and read data
    always_comb begin
        config_d = config_q;
        count_d = count_q;
        fault_d = fault_q;
        shut_d = shut_q;
        cause_d = cause_q;
        rdata_d = rdata_q;
        // counter saturates so a long silence never wraps back below the limits
        if (tick && count_q != 24'hFF_FFFF) begin
            count_d = count_q + 24'h00_0001; // [RL1]
        end
        // a valid frame restarts the silence measurement
        if (frame_valid && !count_clear_inhibit) begin
            count_d = count_reset; // [RL11]
        end
        // a counter byte write wins over the tick and the frame clear for that byte only
        if (reg_wr) begin
            if (reg_addr == silence_period_config_addr) begin
                config_d = reg_wdata;
            end
            if (reg_addr >= silence_tick_counter_addr && reg_addr <= silence_tick_counter_last) begin
                unique case (byte_sel)
                    2'd0: count_d[23:16] = reg_wdata; // [RL3]
                    2'd1: count_d[15:8] = reg_wdata; // [RL3]
                    default: count_d[7:0] = reg_wdata; // [RL3]
                endcase
            end
        end
        // sticky fault: a new expiry wins over a clear in the same cycle
        if (link_silence_fault_clear) begin
            fault_d = 1'b0;
        end
        if (fault_hit && !(frame_valid && !count_clear_inhibit)) begin
            fault_d = 1'b1; // [RL8]
        end
        // shutdown holds until device reset
        if (pd_hit && !(frame_valid && !count_clear_inhibit)) begin
            shut_d = 1'b1; // [RL6]
            cause_d = 1'b1; // [RL12]
        end
        // live read data, registered
        if (reg_rd) begin
            rdata_d = 8'h00;
            if (reg_addr == silence_period_config_addr) begin
                rdata_d = config_q;
            end else if (reg_addr >= silence_tick_counter_addr && reg_addr <= silence_tick_counter_last) begin
                unique case (byte_sel)
                    2'd0: rdata_d = count_q[23:16]; // [RL4]
                    2'd1: rdata_d = count_q[15:8]; // [RL4]
                    default: rdata_d = count_q[7:0]; // [RL4]
                endcase
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            config_q <= config_reset;
            count_q <= count_reset;
            fault_q <= 1'b0;
            shut_q <= 1'b0;
            cause_q <= 1'b0;
            rdata_q <= 8'h00;
        end else begin
            config_q <= config_d;
            count_q <= count_d;
            fault_q <= fault_d;
            shut_q <= shut_d;
            cause_q <= cause_d;
            rdata_q <= rdata_d;
        end
    end

    // decode is combinational handshake
    assign reg_hit = (reg_addr == silence_period_config_addr) ||
                     (reg_addr >= silence_tick_counter_addr && reg_addr <= silence_tick_counter_last);
    assign reg_rdata = rdata_q;
    assign link_silence_fault = fault_q;
    assign shutdown_request = shut_q;
    assign controller_shutdown_cause = cause_q;
    assign silence_tick_count = count_q;
endmodule // comm_silence_timeout

// [verilog/silence_pkg.sv]
// constants shared by the link-silence supervisor
package silence_pkg;
    // ****************************************
    // register map
    // ****************************************
    localparam logic [7:0] silence_period_config_addr = 8'h28;
    localparam logic [7:0] silence_tick_counter_addr = 8'h29; // three bytes 0x29..0x2b, msb first
    localparam logic [7:0] silence_tick_counter_last = 8'h2B;
    localparam logic [7:0] config_reset = 8'h00;
    localparam logic [23:0] count_reset = 24'h00_0000;
    // field positions inside the config byte
    localparam int pd_field_lsb = 4;
    localparam int fault_field_lsb = 0;
    localparam int field_width = 4;
    localparam int count_width = 24;
    // bit of the shutdown status that records a controller shutdown
    localparam int shutdown_cause_bit = 7;
    // ****************************************
    // time base
    // ****************************************
    localparam int clock_hz = 100_000_000;
    localparam int tick_hz = 4_000;
    localparam int tick_div = clock_hz / tick_hz; // 25000 cycles per tick
    // period table in ticks of 4 kHz; index is the field code
    localparam logic [23:0] period_ticks [16] = '{
        24'h00_0000, // 0 disabled
        24'h00_0190, // 0.1 s  = 400
        24'h00_07D0, // 0.5 s  = 2000
        24'h00_0FA0, // 1 s    = 4000
        24'h00_1F40, // 2 s    = 8000
        24'h00_4E20, // 5 s    = 20000
        24'h00_9C40, // 10 s   = 40000
        24'h01_D4C0, // 30 s   = 120000
        24'h03_A980, // 1 min  = 240000
        24'h07_5300, // 2 min  = 480000
        24'h12_4F80, // 5 min  = 1200000
        24'h24_9F00, // 10 min = 2400000
        24'h6D_DD00, // 30 min = 7200000
        24'hDB_BA00, // 1 h    = 14400000
        24'h00_0000, // 14 reserved, treated as disabled
        24'h00_0000  // 15 reserved, treated as disabled
    };
endpackage

// [verilog/tick_divider.sv]
// one-cycle enable pulse at the slow time-base rate
`timescale 1ns/1ns
module tick_divider
    import silence_pkg::*;
#(
    parameter int divide = tick_div
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // slow enable
    output logic tick
);
    localparam int cnt_w = $clog2(divide);

    initial begin
        if (divide < 2) begin
            $error("tick_divider: divide must be at least 2");
        end
    end

    logic [cnt_w-1:0] cnt_q;
    logic [cnt_w-1:0] cnt_d;
    logic tick_q;
    logic tick_d;

    // wrap at divide-1 and pulse once per wrap
    always_comb begin
        tick_d = 1'b0;
        cnt_d = cnt_q + 1'b1;
        if (cnt_q == cnt_w'(divide - 1)) begin
            cnt_d = '0;
            tick_d = 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            cnt_q <= '0;
            tick_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            tick_q <= tick_d;
        end
    end

    assign tick = tick_q;
endmodule // tick_divider
